// >>> include/cms_pkg.sv
// constants and types shared by the cell monitor serial slave files
// assumes a 10 MHz system clock and a host-driven serial clock
package cms_pkg;

    // frame geometry
    localparam int unsigned WORD_W     = 48;
    localparam int unsigned FIELD_CNT  = 6;
    localparam int unsigned CNT_W      = 6;

    // bit counter values
    localparam logic [5:0] CNT_RESET   = 6'h00;
    localparam logic [5:0] CNT_LAST    = 6'h2f;
    localparam logic [5:0] CNT_OVER    = 6'h30;

    // buffering between link and user side
    localparam int unsigned FIFO_DEPTH = 8;

    // values after reset
    localparam logic [47:0] WORD_RESET = 48'h0000_0000_0000;

    // receive path states in the system domain
    typedef enum logic [2:0] {
        CMS_IDLE  = 3'b001,
        CMS_FRAME = 3'b010,
        CMS_HOLD  = 3'b100
    } cms_rx_state_t;

endpackage

// >>> src/cms_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module cms_fifo #(
    parameter int unsigned WIDTH = 48,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 fill;
    } cms_fifo_state_t;

    cms_fifo_state_t st;
    cms_fifo_state_t next_st;
    logic            push;
    logic            pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    assign in_ready  = (st.fill != (AW+1)'(DEPTH));
    assign out_valid = (st.fill != '0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = bump(st.wr);
        end
        if (pop) begin
            next_st.rd = bump(st.rd);
        end
        if (push && !pop) begin
            next_st.fill = st.fill + 1'b1;
        end else if (pop && !push) begin
            next_st.fill = st.fill - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> src/cms_spi_slave.sv
// serial slave port of a cell monitor: 48-bit frames, replies one behind
// assumes the host drives sclk, mosi and chip_select_n (mode 0)
// Functional notes
// RULE1: slave only; chip select low, never initiates
// RULE2: both directions shift most significant bit first
// RULE3: exactly 48 bits, six fields; others rejected
// RULE4: reply shifted is word staged for previous request
// RULE5: host clocks all; extra frame fetches last reply
// RULE6: output released when deselected; partial frames dropped
`timescale 1ns/1ps
module cms_spi_slave #(
    parameter int unsigned WIDTH = cms_pkg::WORD_W,
    parameter int unsigned DEPTH = cms_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             sclk,
    input  wire logic             chip_select_n,
    input  wire logic             mosi,
    output logic                  miso,
    output logic                  miso_oe,
    output logic                  req_valid,
    input  wire logic             req_ready,
    output logic      [WIDTH-1:0] req_data,
    input  wire logic             reply_valid,
    output logic                  reply_ready,
    input  wire logic [WIDTH-1:0] reply_data,
    output logic                  frame_err,
    output logic                  overrun,
    output logic                  busy
);

    // ---------------- link domain (sclk) ----------------

    typedef struct packed {
        logic [5:0]       cnt;
        logic [WIDTH-1:0] shin;
        logic [WIDTH-1:0] shout;
    } cms_link_t;

    typedef struct packed {
        logic [WIDTH-1:0] word;
        logic             word_tgl;
        logic             bad_tgl;
    } cms_hand_t;

    cms_link_t  lk;
    cms_link_t  next_lk;
    cms_hand_t  hd;
    cms_hand_t  next_hd;
    logic       frame_nrst;
    logic       miso_q;
    logic [WIDTH-1:0] stage;

    // frame state cleared while deselected [RULE6]
    assign frame_nrst = nrst && !chip_select_n;

    always_comb begin
        next_lk = lk;
        next_hd = hd;
        // sample on rising edge, msb first [RULE2]
        next_lk.shin = {lk.shin[WIDTH-2:0], mosi};
        if (lk.cnt == cms_pkg::CNT_RESET) begin
            // capture staged reply on first edge [RULE4]
            next_lk.shout = {stage[WIDTH-2:0], 1'b0};
        end else begin
            next_lk.shout = {lk.shout[WIDTH-2:0], 1'b0};
        end
        if (lk.cnt == cms_pkg::CNT_LAST) begin
            // full word handed over [RULE3]
            next_hd.word     = {lk.shin[WIDTH-2:0], mosi};
            next_hd.word_tgl = !hd.word_tgl;
        end
        if (lk.cnt == cms_pkg::CNT_OVER) begin
            // 49th edge marks an overlong frame [RULE3]
            next_hd.bad_tgl = !hd.bad_tgl;
        end
        // parks one past the mark so the flag toggles once [RULE3]
        if (lk.cnt <= cms_pkg::CNT_OVER) begin
            next_lk.cnt = lk.cnt + 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge frame_nrst) begin
        if (!frame_nrst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            hd <= '0;
        end else begin
            hd <= next_hd;
        end
    end

    // output changes on falling edge, msb first [RULE2]
    always_ff @(negedge sclk or negedge frame_nrst) begin
        if (!frame_nrst) begin
            miso_q <= 1'b0;
        end else if (lk.cnt == 6'h01) begin
            miso_q <= stage[WIDTH-2];
        end else begin
            miso_q <= lk.shout[WIDTH-1];
        end
    end

    // first bit ready as soon as selected [RULE4]
    assign miso    = (lk.cnt == cms_pkg::CNT_RESET) ? stage[WIDTH-1]
                                                    : miso_q;
    // driven only while selected [RULE1] [RULE6]
    assign miso_oe = !chip_select_n;

    // ---------------- system domain (clk) ----------------

    typedef struct packed {
        logic [1:0]          cs_sync;
        logic [1:0]          word_sync;
        logic [1:0]          bad_sync;
        logic                word_seen;
        logic                bad_seen;
        cms_pkg::cms_rx_state_t state;
        logic                bad;
        logic [WIDTH-1:0]    pend;
        logic [WIDTH-1:0]    stage;
        logic                frame_err;
        logic                overrun;
    } cms_sys_t;

    cms_sys_t         sy;
    cms_sys_t         next_sy;
    logic             cs_idle;
    logic             word_ev;
    logic             bad_ev;
    logic             push;
    logic             push_ready;

    assign cs_idle = sy.cs_sync[1];
    assign word_ev = sy.word_sync[1] != sy.word_seen;
    assign bad_ev  = sy.bad_sync[1] != sy.bad_seen;
    assign stage   = sy.stage;

    always_comb begin
        next_sy           = sy;
        push              = 1'b0;
        next_sy.cs_sync   = {sy.cs_sync[0], chip_select_n};
        next_sy.word_sync = {sy.word_sync[0], hd.word_tgl};
        next_sy.bad_sync  = {sy.bad_sync[0], hd.bad_tgl};
        next_sy.word_seen = sy.word_sync[1];
        next_sy.bad_seen  = sy.bad_sync[1];
        next_sy.frame_err = 1'b0;
        next_sy.overrun   = 1'b0;
        unique case (sy.state)
            cms_pkg::CMS_IDLE: begin
                if (!cs_idle) begin
                    next_sy.state = cms_pkg::CMS_FRAME;
                    next_sy.bad   = 1'b0;
                end
            end
            cms_pkg::CMS_FRAME: begin
                // extra edge may arrive with the word [RULE3]
                if (bad_ev) begin
                    next_sy.bad = 1'b1;
                end
                if (word_ev) begin
                    // word stable until the next frame ends
                    next_sy.pend  = hd.word;
                    next_sy.state = cms_pkg::CMS_HOLD;
                end else if (cs_idle) begin
                    // short frame dropped [RULE3] [RULE6]
                    next_sy.frame_err = 1'b1;
                    next_sy.state     = cms_pkg::CMS_IDLE;
                end
            end
            cms_pkg::CMS_HOLD: begin
                if (bad_ev) begin
                    next_sy.bad = 1'b1;
                end
                if (cs_idle) begin
                    next_sy.state = cms_pkg::CMS_IDLE;
                    if (sy.bad || bad_ev) begin
                        // overlong frame dropped [RULE3]
                        next_sy.frame_err = 1'b1;
                    end else if (push_ready) begin
                        push = 1'b1;
                    end else begin
                        next_sy.overrun = 1'b1;
                    end
                end
            end
            default: begin
                next_sy.state = cms_pkg::CMS_IDLE;
            end
        endcase
        // reply staged only between frames [RULE4] [RULE5]
        if (reply_valid && cs_idle &&
            sy.state == cms_pkg::CMS_IDLE) begin
            next_sy.stage = reply_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sy         <= '0;
            sy.cs_sync <= 2'h3;
            sy.state   <= cms_pkg::CMS_IDLE;
            sy.pend    <= cms_pkg::WORD_RESET;
            sy.stage   <= cms_pkg::WORD_RESET;
        end else begin
            sy <= next_sy;
        end
    end

    assign reply_ready = cs_idle && (sy.state == cms_pkg::CMS_IDLE);
    assign frame_err   = sy.frame_err;
    assign overrun     = sy.overrun;
    assign busy        = !cs_idle;

    cms_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (sy.pend),
        .out_valid (req_valid),
        .out_ready (req_ready),
        .out_data  (req_data)
    );

endmodule

// >>> verif/cell_monitor_spi_slave_tb_top.sv
// self-checking bench of the cell monitor serial slave
// assumes cms_host on the link side, user side driven here
`timescale 1ns/1ps
module cell_monitor_spi_slave_tb_top;
    logic        clk, nrst, hold, req_ready, reply_valid;
    logic [47:0] reply_data, req_data, got, w, r;
    logic        miso, miso_oe, req_valid, reply_ready;
    logic        frame_err, overrun, busy;
    wire         sclk, cs_n, mosi, miso_w;
    int          bad_count, total_checks, err_cnt, ovr_cnt;
    logic [47:0] exp_q[$];
    logic [47:0] exp_w;
    assign miso_w = miso_oe ? miso : ~miso;
    cms_spi_slave cms_spi_slave_inst (
        .clk(clk), .nrst(nrst), .sclk(sclk), .chip_select_n(cs_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .reply_valid(reply_valid),
        .reply_ready(reply_ready), .reply_data(reply_data),
        .frame_err(frame_err), .overrun(overrun), .busy(busy)
    );
    cms_host cms_host_inst (
        .sclk(sclk), .chip_select_n(cs_n), .mosi(mosi), .miso(miso_w)
    );
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic cmp(input logic [47:0] g, input logic [47:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic stage(input logic [47:0] v);
        logic taken;
        taken = 1'b0;
        @(posedge clk);
        reply_valid <= 1'b1;
        reply_data <= v;
        for (int i = 0; i < 20 && !taken; i++) begin
            @(posedge clk);
            taken = (reply_ready === 1'b1);
        end
        reply_valid <= 1'b0;
        cmp({47'h0, taken}, 48'h1);
    endtask
    task automatic xfer(input logic [47:0] v, input int n);
        repeat (5) @(posedge clk);
        #13;
        cms_host_inst.frame(v, n, got);
        repeat (8) @(posedge clk);
    endtask
    // monitor: popped words against the oldest note
    always @(posedge clk) begin
        if (req_valid === 1'b1 && req_ready === 1'b1) begin
            exp_w = exp_q.size() ? exp_q.pop_front() : ~req_data;
            cmp(req_data, exp_w);
        end
        if (frame_err === 1'b1) err_cnt++;
        if (overrun === 1'b1) ovr_cnt++;
        req_ready <= hold ? 1'b0 : 1'($urandom % 2);
    end
    initial begin
        #500000;
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(98166));
        nrst = 1'b0;
        hold = 1'b1;
        reply_valid = 1'b0;
        reply_data = 48'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cmp({46'h0, reply_ready, req_valid}, 48'h2);
        hold <= 1'b0;
        r = 48'h0;
        for (int k = 0; k < 6; k++) begin
            w = 48'({$urandom, $urandom});
            exp_q.push_back(w);
            xfer(w, 48);
            cmp(got, r);
            if (k < 4) begin
                r = 48'({$urandom, $urandom});
                stage(r);
            end
        end
        xfer(w, 20);
        cmp(got, 48'(r[47:28]));
        xfer(w, 49);
        cmp(got, {r[46:0], 1'b0});
        cmp(48'(err_cnt), 48'h2);
        hold <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            w = 48'({$urandom, $urandom});
            if (k < 8) exp_q.push_back(w);
            xfer(w, 48);
            cmp(got, r);
        end
        cmp(48'(ovr_cnt), 48'h1);
        hold <= 1'b0;
        repeat (80) @(posedge clk);
        cmp(48'(exp_q.size()), 48'h0);
        stop_test();
    end
endmodule

// >>> verif/cms_host.sv
// host master model of the serial link
// assumes mode 0, link clock 64 ns, only inside frames
`timescale 1ns/1ps
module cms_host (
    output logic      sclk,
    output logic      chip_select_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end
    // host starts and clocks every frame
    task automatic frame(input logic [47:0] w, input int n,
                         output logic [47:0] r);
        r = 48'h0;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = w[47 - (i % 48)];
            #32 sclk = 1'b1;
            r = {r[46:0], miso};
            #32 sclk = 1'b0;
        end
        mosi = ~mosi;
        #32 chip_select_n = 1'b1;
    endtask
endmodule

// >>> verif/cms_spi_slave_assertions.sv
// checker on the serial slave top ports
// assumes it is bound onto cms_spi_slave
`timescale 1ns/1ps
module cms_spi_slave_assertions #(
    parameter int unsigned WIDTH = 48
) (
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             chip_select_n,
    input wire logic             miso_oe,
    input wire logic             req_valid,
    input wire logic             req_ready,
    input wire logic [WIDTH-1:0] req_data,
    input wire logic             reply_ready,
    input wire logic             frame_err,
    input wire logic             overrun,
    input wire logic             busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_oe; miso_oe == !chip_select_n; endproperty
    a_oe: assert property (p_oe) else $error("oe wrong");
    property p_busy; $fell(chip_select_n) |-> ##[1:4] busy; endproperty
    a_busy: assert property (p_busy) else $error("no busy");
    property p_stage; $fell(busy) |-> !reply_ready; endproperty
    a_stage: assert property (p_stage) else $error("stage open");
    property p_err; frame_err |=> !frame_err; endproperty
    a_err: assert property (p_err) else $error("err long");
    property p_ovr; overrun |=> !overrun; endproperty
    a_ovr: assert property (p_ovr) else $error("ovr long");
    property p_errcs; frame_err |-> chip_select_n; endproperty
    a_errcs: assert property (p_errcs) else $error("err early");
    property p_push; $rose(req_valid) |-> chip_select_n; endproperty
    a_push: assert property (p_push) else $error("push early");
    property p_hold;
        req_valid && !req_ready |=> req_valid && $stable(req_data);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    c_err: cover property (frame_err);
    c_ovr: cover property (overrun);
    c_pop: cover property (req_valid && req_ready);
endmodule

bind cms_spi_slave cms_spi_slave_assertions #(.WIDTH(WIDTH)) chk_inst (
    .clk(clk), .nrst(nrst), .chip_select_n(chip_select_n),
    .miso_oe(miso_oe), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .reply_ready(reply_ready),
    .frame_err(frame_err), .overrun(overrun), .busy(busy)
);
